// file: sepc_core.sv
// serial eeprom slave: link decode, protection status and page write
//
// Overview of operation
// RULE_01 - sample input bits on each rising serial clock edge while selected
// RULE_02 - drive output bit on falling serial clock edge, idle-low or idle-high
// RULE_03 - every byte moves most significant bit first
// RULE_04 - first byte is opcode; unknown opcode keeps output off, no action
// RULE_05 - master frames each instruction with select low, raises it at end
// RULE_06 - pending write cycle starts when select rises after write instruction
// RULE_07 - deselected: standby unless writing, output kept high impedance
// RULE_08 - hold low pauses sequence, ignores clock and data, resumes on release
// RULE_09 - master changes hold only while serial clock is low
// RULE_10 - status: arm bit 7, unused 6-4, guards 3-2, latch 1, busy 0
// RULE_11 - during a write cycle every status bit reads one
// RULE_12 - busy reads one while writing; only status read accepted then
// RULE_13 - status writes need latch set and hardware protection inactive
// RULE_14 - latch clear blocks all writes; only set-latch sets it; clear at power-up
// RULE_15 - guard codes: none, 600h-7ffh, 400h-7ffh, whole array
// RULE_16 - guard bits nonvolatile, factory zero; guarded range never writable (bg_reg reloads BG_FACTORY on every reset)
// RULE_17 - status bits 6 to 4 ignore writes and read zero
// RULE_18 - hardware protection is pin low with arm set; locks status only
// RULE_19 - arm bit cannot go from one to zero while protect pin low
// RULE_20 - array is 2048 bytes addressed by eleven bits
// RULE_21 - writes cover one 32-byte page, partial pages allowed
// RULE_22 - opcode set with bit 3 ignored
// RULE_23 - latch clears when clear-latch, status-write or array-write completes
// RULE_24 - array read streams bytes, wrapping top address to zero
// RULE_25 - array write wraps inside its page, keeping the last 32 bytes
// RULE_26 - write cycle length is a parameter count, busy clears at expiry
`timescale 1ns/100ps
module sepc_core import sepc_pkg::*; #(
  parameter int WRITE_CYCLES = 1000
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  input wire logic hold_n_i,
  input wire logic wp_n_i,
  output logic so_o,
  output logic so_oe_o
);

  localparam logic [WC_W-1:0] WC_LAST = WC_W'(WRITE_CYCLES - 1);

  // ----------------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------------
  logic cs_m, sck_m, si_m, hold_m, wp_m;
  logic cs_s, sck_s, si_s, hold_s, wp_s;
  logic cs_d, sck_d;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      {cs_m, sck_m, si_m, hold_m, wp_m} <= 5'h13;
      {cs_s, sck_s, si_s, hold_s, wp_s} <= 5'h13;
      cs_d <= 1'b1;
      sck_d <= 1'b0;
    end else begin
      {cs_m, sck_m, si_m, hold_m, wp_m} <= {cs_n_i, sck_i, si_i, hold_n_i, wp_n_i};
      {cs_s, sck_s, si_s, hold_s, wp_s} <= {cs_m, sck_m, si_m, hold_m, wp_m};
      cs_d <= cs_s;
      sck_d <= sck_s;
    end
  end

  // si and hold share the sck latency, so they line up with the edges [RULE_09]
  logic sck_rise, sck_fall, cs_rise, act;
  assign sck_rise = sck_s & ~sck_d;
  assign sck_fall = ~sck_s & sck_d;
  assign cs_rise = cs_s & ~cs_d;
  assign act = ~cs_s & hold_s; // [RULE_05] [RULE_08]

  // ----------------------------------------------------------------------
  // state declarations
  // ----------------------------------------------------------------------
  sepc_phase_t phase_reg;
  sepc_cmd_t cmd_reg, op_cmd;
  sepc_wc_t wc_state;
  logic [7:0] rx_reg, byte_val, out_reg, sr_new_reg, status_view, tx_src;
  logic [2:0] bit_cnt_reg;
  logic [ADDR_W-1:0] addr_reg, arr_waddr;
  logic [PAGE_BYTES-1:0] mask_reg;
  logic [5:0] cp_cnt_reg;
  logic [PAGE_W-1:0] cp_prev;
  logic [WC_W-1:0] wc_cnt_reg;
  logic [1:0] bg_reg;
  logic arm_reg, wen_reg, busy_reg, sr_cycle_reg, got_data_reg;
  logic so_reg, so_oe_reg, out_on_reg;
  logic byte_done, tx_phase, tx_load, hw_prot, wr_go, pb_we, arr_we;
  logic [7:0] arr_rdata, pb_rdata;

  // ----------------------------------------------------------------------
  // receive shifter
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || cs_s) begin
      bit_cnt_reg <= '0;
      rx_reg <= '0;
    end else if (act && sck_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1; // [RULE_01]
      rx_reg <= {rx_reg[6:0], si_s}; // [RULE_03]
    end
  end

  assign byte_done = act & sck_rise & (bit_cnt_reg == BIT_LAST);
  assign byte_val = {rx_reg[6:0], si_s};
  assign op_cmd = sepc_decode(byte_val); // [RULE_22]

  // ----------------------------------------------------------------------
  // instruction sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || cs_s) begin
      phase_reg <= PH_OPC;
      cmd_reg <= CMD_NONE;
    end else if (byte_done) begin
      case (phase_reg)
        PH_OPC: begin
          // a bad opcode, or anything but status read while busy, is dropped
          if (op_cmd == CMD_NONE || (busy_reg && op_cmd != CMD_SRD)) begin
            phase_reg <= PH_IGN; // [RULE_04] [RULE_12]
          end else begin
            cmd_reg <= op_cmd;
            case (op_cmd)
              CMD_ARD, CMD_AWR: phase_reg <= PH_AHI;
              CMD_SRD, CMD_SWR: phase_reg <= PH_DATA;
              default: phase_reg <= PH_DONE;
            endcase
          end
        end
        PH_AHI: phase_reg <= PH_ALO;
        PH_ALO: phase_reg <= PH_DATA;
        PH_DONE: phase_reg <= PH_IGN;
        default: phase_reg <= phase_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // byte address and write payload
  // ----------------------------------------------------------------------
  assign pb_we = byte_done & (phase_reg == PH_DATA) & (cmd_reg == CMD_AWR);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      addr_reg <= '0;
    end else if (byte_done && phase_reg == PH_AHI) begin
      addr_reg <= {byte_val[2:0], addr_reg[7:0]}; // [RULE_20]
    end else if (byte_done && phase_reg == PH_ALO) begin
      addr_reg <= {addr_reg[10:8], byte_val};
    end else if (pb_we) begin
      addr_reg <= {addr_reg[10:5], addr_reg[4:0] + 5'h1}; // [RULE_25]
    end else if (tx_load && cmd_reg == CMD_ARD) begin
      addr_reg <= addr_reg + 11'h1; // [RULE_24]
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      got_data_reg <= 1'b0;
      sr_new_reg <= '0;
      mask_reg <= '0;
    end else if (byte_done && phase_reg == PH_OPC) begin
      got_data_reg <= 1'b0;
      if (op_cmd == CMD_AWR && !busy_reg) begin
        mask_reg <= '0;
      end
    end else if (byte_done && phase_reg == PH_DATA) begin
      got_data_reg <= 1'b1;
      if (cmd_reg == CMD_SWR) begin
        sr_new_reg <= byte_val;
      end
      if (cmd_reg == CMD_AWR) begin
        mask_reg[addr_reg[4:0]] <= 1'b1; // [RULE_21]
      end
    end
  end

  // ----------------------------------------------------------------------
  // status view and transmit path
  // ----------------------------------------------------------------------
  always_comb begin
    status_view = '0; // [RULE_17]
    if (busy_reg) begin
      status_view = SR_BUSY_VIEW; // [RULE_11] [RULE_12]
    end else begin
      status_view[SR_ARM] = arm_reg; // [RULE_10]
      status_view[SR_BG_HI] = bg_reg[1];
      status_view[SR_BG_LO] = bg_reg[0];
      status_view[SR_LATCH] = wen_reg;
    end
  end

  assign tx_phase = (phase_reg == PH_DATA) & (cmd_reg == CMD_SRD || cmd_reg == CMD_ARD);
  assign tx_load = act & sck_fall & tx_phase & (bit_cnt_reg == '0);
  assign tx_src = (cmd_reg == CMD_SRD) ? status_view : arr_rdata;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      out_reg <= '0;
      so_reg <= 1'b0;
      out_on_reg <= 1'b0;
    end else if (cs_s) begin
      out_on_reg <= 1'b0;
    end else if (act && sck_fall && tx_phase) begin
      if (bit_cnt_reg == '0) begin
        out_reg <= tx_src;
        so_reg <= tx_src[7]; // [RULE_02] [RULE_03]
        out_on_reg <= 1'b1;
      end else begin
        out_reg <= {out_reg[6:0], 1'b0};
        so_reg <= out_reg[6];
      end
    end
  end

  // the pin is released during hold and while deselected
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      so_oe_reg <= 1'b0;
    end else begin
      so_oe_reg <= act & tx_phase & out_on_reg; // [RULE_07] [RULE_08]
    end
  end

  assign so_o = so_reg;
  assign so_oe_o = so_oe_reg;

  // ----------------------------------------------------------------------
  // write latch
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wen_reg <= 1'b0; // [RULE_14]
    end else if (cs_rise && bit_cnt_reg == '0) begin
      if (cmd_reg == CMD_SET && phase_reg == PH_DONE) begin
        wen_reg <= 1'b1; // [RULE_14]
      end else if ((cmd_reg == CMD_CLR && phase_reg == PH_DONE) ||
                   ((cmd_reg == CMD_SWR || cmd_reg == CMD_AWR) &&
                    phase_reg == PH_DATA && got_data_reg)) begin
        wen_reg <= 1'b0; // [RULE_23]
      end
    end
  end

  // ----------------------------------------------------------------------
  // internal write cycle
  // ----------------------------------------------------------------------
  assign hw_prot = arm_reg & ~wp_s; // [RULE_18]
  // a frame cut mid-byte or without data is not a complete write
  assign wr_go = cs_rise & (bit_cnt_reg == '0) & (phase_reg == PH_DATA) & got_data_reg &
                 wen_reg & ((cmd_reg == CMD_AWR) || (cmd_reg == CMD_SWR && !hw_prot)); // [RULE_13]

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wc_state <= WC_IDLE;
      busy_reg <= 1'b0;
      sr_cycle_reg <= 1'b0;
      cp_cnt_reg <= '0;
      wc_cnt_reg <= '0;
    end else begin
      case (wc_state)
        WC_IDLE: begin
          if (wr_go) begin
            busy_reg <= 1'b1; // [RULE_06]
            sr_cycle_reg <= (cmd_reg == CMD_SWR);
            wc_state <= (cmd_reg == CMD_AWR) ? WC_COPY : WC_WAIT;
            cp_cnt_reg <= '0;
            wc_cnt_reg <= '0;
          end
        end
        WC_COPY: begin
          cp_cnt_reg <= cp_cnt_reg + 6'h1;
          wc_cnt_reg <= wc_cnt_reg + 1'b1;
          if (cp_cnt_reg == PAGE_BYTES) begin
            wc_state <= WC_WAIT;
          end
        end
        WC_WAIT: begin
          wc_cnt_reg <= wc_cnt_reg + 1'b1;
          if (wc_cnt_reg == WC_LAST) begin
            busy_reg <= 1'b0; // [RULE_26]
            wc_state <= WC_IDLE;
          end
        end
        default: wc_state <= WC_IDLE;
      endcase
    end
  end

  // guard and arm bits only change as the status write cycle ends
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      bg_reg <= BG_FACTORY; // [RULE_16]
      arm_reg <= ARM_RESET;
    end else if (wc_state == WC_WAIT && wc_cnt_reg == WC_LAST && sr_cycle_reg) begin
      bg_reg <= {sr_new_reg[SR_BG_HI], sr_new_reg[SR_BG_LO]};
      arm_reg <= (arm_reg && !wp_s) ? 1'b1 : sr_new_reg[SR_ARM]; // [RULE_19]
    end
  end

  // page copy: buffer read one cycle ahead of the array write
  assign cp_prev = cp_cnt_reg[4:0] - 5'h1;
  assign arr_waddr = {addr_reg[10:5], cp_prev};
  assign arr_we = (wc_state == WC_COPY) & (cp_cnt_reg != '0) & mask_reg[cp_prev] &
                  ~sepc_guarded(bg_reg, arr_waddr); // [RULE_15] [RULE_16]

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  sepc_mem #(.AW(PAGE_W), .DW(8)) u_page (
    .clk_sys_i(clk_sys_i),
    .we_i(pb_we),
    .waddr_i(addr_reg[4:0]),
    .wdata_i(byte_val),
    .raddr_i(cp_cnt_reg[4:0]),
    .rdata_o(pb_rdata)
  );

  sepc_mem #(.AW(ADDR_W), .DW(8)) u_array (
    .clk_sys_i(clk_sys_i),
    .we_i(arr_we),
    .waddr_i(arr_waddr),
    .wdata_i(pb_rdata),
    .raddr_i(addr_reg),
    .rdata_o(arr_rdata)
  );

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  chk_sample_rise: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE_01]
    $changed(bit_cnt_reg) |-> $past(sck_rise) || $past(cs_s))
    else $error("bit counter moved without a rising clock");

  chk_out_on_fall: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE_02]
    $changed(so_reg) |-> $past(sck_fall) && $past(act))
    else $error("output bit changed off a falling clock");

  chk_badop_hiz: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE_04]
    (phase_reg == PH_IGN) ##1 (phase_reg == PH_IGN) |-> !so_oe_reg)
    else $error("output driven after a refused opcode");

  chk_start_at_cs: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE_06]
    $rose(busy_reg) |-> $past(cs_rise))
    else $error("write cycle started away from select rise");

  chk_idle_hiz: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE_07]
    cs_s |=> !so_oe_reg)
    else $error("output driven while deselected");

  chk_hold_freeze: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE_08]
    !hold_s && !cs_s |=> $stable(bit_cnt_reg) && $stable(so_reg) && !so_oe_reg)
    else $error("sequence moved during hold");

  chk_busy_ones: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE_11]
    busy_reg |-> status_view == SR_BUSY_VIEW)
    else $error("status not all ones while busy");

  chk_busy_only_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE_12]
    busy_reg && byte_done && phase_reg == PH_OPC && op_cmd != CMD_SRD |=> phase_reg == PH_IGN)
    else $error("instruction accepted while busy");

  chk_sr_lock: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE_13]
    $rose(busy_reg) && sr_cycle_reg |-> !$past(hw_prot) && $past(wen_reg))
    else $error("status write started while locked");

  chk_latch_needed: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE_14]
    $rose(busy_reg) |-> $past(wen_reg))
    else $error("write cycle started with latch clear");

  chk_guard_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE_16]
    arr_we |-> !sepc_guarded(bg_reg, arr_waddr))
    else $error("guarded byte written");

  chk_unused_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE_17]
    !busy_reg |-> status_view[6:4] == 3'h0)
    else $error("unused status bits not zero");

  chk_arm_keep: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE_19]
    $fell(arm_reg) |-> $past(wp_s))
    else $error("arm cleared with protect pin low");

  chk_latch_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE_23]
    $rose(busy_reg) |-> !wen_reg)
    else $error("latch left set after a write");

  chk_read_wrap: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE_24]
    tx_load && cmd_reg == CMD_ARD |=> addr_reg == ($past(addr_reg) + 11'h1))
    else $error("read address did not advance");

  chk_page_wrap: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE_25]
    pb_we |=> addr_reg[10:5] == $past(addr_reg[10:5]))
    else $error("write address left its page");

  chk_busy_end: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE_26]
    wc_state == WC_WAIT && wc_cnt_reg == WC_LAST |=> !busy_reg ##1 !busy_reg)
    else $error("busy held past the write count");

endmodule : sepc_core

// file: sepc_pkg.sv
// package: constants, types and helpers of the serial eeprom protect core
package sepc_pkg;

  // ----------------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 11;
  localparam int PAGE_W = 5;
  localparam logic [5:0] PAGE_BYTES = 6'h20;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int WC_W = 20;

  // ----------------------------------------------------------------------
  // opcodes, compared after masking bit 3
  // ----------------------------------------------------------------------
  localparam logic [7:0] OPC_MASK = 8'hf7;
  localparam logic [7:0] OPC_SET_LATCH = 8'h06;
  localparam logic [7:0] OPC_CLR_LATCH = 8'h04;
  localparam logic [7:0] OPC_STAT_RD = 8'h05;
  localparam logic [7:0] OPC_STAT_WR = 8'h01;
  localparam logic [7:0] OPC_ARR_RD = 8'h03;
  localparam logic [7:0] OPC_ARR_WR = 8'h02;

  // ----------------------------------------------------------------------
  // protection_status layout and reset values
  // ----------------------------------------------------------------------
  localparam int SR_ARM = 7;
  localparam int SR_BG_HI = 3;
  localparam int SR_BG_LO = 2;
  localparam int SR_LATCH = 1;
  localparam int SR_BUSY = 0;
  localparam logic [7:0] SR_BUSY_VIEW = 8'hff;
  localparam logic [1:0] BG_FACTORY = 2'h0;
  localparam logic ARM_RESET = 1'b0;

  // ----------------------------------------------------------------------
  // block guard levels
  // ----------------------------------------------------------------------
  localparam logic [1:0] BG_QTR = 2'h1;
  localparam logic [1:0] BG_HALF = 2'h2;
  localparam logic [1:0] BG_ALL = 2'h3;
  localparam logic [ADDR_W-1:0] GUARD_QTR_BASE = 11'h600;
  localparam logic [ADDR_W-1:0] GUARD_HALF_BASE = 11'h400;

  typedef enum logic [2:0] {
    PH_OPC = 3'b000, PH_AHI = 3'b001, PH_ALO = 3'b010,
    PH_DATA = 3'b011, PH_DONE = 3'b100, PH_IGN = 3'b101
  } sepc_phase_t;

  typedef enum logic [1:0] {
    WC_IDLE = 2'b00, WC_COPY = 2'b01, WC_WAIT = 2'b10
  } sepc_wc_t;

  typedef enum logic [2:0] {
    CMD_NONE = 3'b000, CMD_SET = 3'b001, CMD_CLR = 3'b010, CMD_SRD = 3'b011,
    CMD_SWR = 3'b100, CMD_ARD = 3'b101, CMD_AWR = 3'b110
  } sepc_cmd_t;

  function automatic sepc_cmd_t sepc_decode(input logic [7:0] op);
    case (op & OPC_MASK)
      OPC_SET_LATCH: sepc_decode = CMD_SET;
      OPC_CLR_LATCH: sepc_decode = CMD_CLR;
      OPC_STAT_RD: sepc_decode = CMD_SRD;
      OPC_STAT_WR: sepc_decode = CMD_SWR;
      OPC_ARR_RD: sepc_decode = CMD_ARD;
      OPC_ARR_WR: sepc_decode = CMD_AWR;
      default: sepc_decode = CMD_NONE;
    endcase
  endfunction : sepc_decode

  function automatic logic sepc_guarded(input logic [1:0] bg,
                                        input logic [ADDR_W-1:0] a);
    case (bg)
      BG_QTR: sepc_guarded = (a >= GUARD_QTR_BASE);
      BG_HALF: sepc_guarded = (a >= GUARD_HALF_BASE);
      BG_ALL: sepc_guarded = 1'b1;
      default: sepc_guarded = 1'b0;
    endcase
  endfunction : sepc_guarded

endpackage : sepc_pkg

// file: sepc_mem.sv
// small two-port memory with registered read data
`timescale 1ns/100ps
module sepc_mem #(
  parameter int AW = 11,
  parameter int DW = 8
) (
  input wire logic clk_sys_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);

  logic [DW-1:0] cells [0:(1<<AW)-1];

  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      cells[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    rdata_o <= cells[raddr_i];
  end

endmodule : sepc_mem

// file: sepc_spi_master.sv
// spi master model driving the link of the eeprom core
`timescale 1ns/100ps
module sepc_spi_master (
  input wire logic clk_sys_i,
  input wire logic so_i,
  input wire logic so_oe_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o,
  output logic hold_n_o,
  output logic [7:0] rx_o,
  output logic rx_vld_o
);
  // ----------------------------------------------------------------
  // framing and bit shifting, half clock period is 4 system clocks
  // ----------------------------------------------------------------
  logic idle_hi = 1'b0;
  logic last_b = 1'b0;
  logic so_w;
  // a released line shows the inverse of the last bit, never a kind constant
  assign so_w = so_oe_i ? so_i : ~last_b;
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
    hold_n_o = 1'b1;
    rx_o = 8'h00;
    rx_vld_o = 1'b0;
  end
  task automatic half();
    repeat (4) @(negedge clk_sys_i);
  endtask : half
  task automatic begin_f(input logic m3);
    idle_hi = m3;
    sck_o = m3;
    half();
    cs_n_o = 1'b0;
    half();
  endtask : begin_f
  task automatic end_f();
    if (!idle_hi) sck_o = 1'b0;
    half();
    cs_n_o = 1'b1;
    si_o = ~si_o;
    half();
    half();
  endtask : end_f
  task automatic xfer(input logic [7:0] tx, input logic chk, input int hb);
    logic [7:0] r;
    for (int i = 7; i >= 0; i--) begin
      sck_o = 1'b0;
      si_o = tx[i];
      half();
      if (i == hb) begin
        // clock and data churn while held; the core must not count them
        hold_n_o = 1'b0;
        si_o = ~tx[i];
        half();
        sck_o = 1'b1;
        half();
        sck_o = 1'b0;
        si_o = tx[i];
        half();
        hold_n_o = 1'b1;
        half();
      end
      sck_o = 1'b1;
      half();
      r[i] = so_w;
      last_b = so_w;
    end
    if (chk) begin
      rx_o = r;
      rx_vld_o = 1'b1;
      @(negedge clk_sys_i);
      rx_vld_o = 1'b0;
    end
  endtask : xfer
endmodule : sepc_spi_master

// file: sepc_core_bench.sv
// testbench of the serial eeprom protect core
`timescale 1ns/100ps
module sepc_core_bench import sepc_pkg::*; ();
  // ----------------------------------------------------------------
  // harness
  // ----------------------------------------------------------------
  localparam int WC = 400;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic wp_n = 1'b1;
  logic oe_seen = 1'b0;
  logic cs_n, sck, si, hold_n, so, so_oe, rx_vld;
  logic [7:0] rx;
  logic [7:0] d [0:3];
  logic [7:0] exp_q [$];
  int error_cnt = 0;
  int checks_done = 0;
  always #20 clk_sys = ~clk_sys;
  sepc_core #(.WRITE_CYCLES(WC)) sepc_core_inst (.clk_sys_i(clk_sys), .rst_n_i(rst_n),
    .cs_n_i(cs_n), .sck_i(sck), .si_i(si), .hold_n_i(hold_n), .wp_n_i(wp_n),
    .so_o(so), .so_oe_o(so_oe));
  sepc_spi_master sepc_spi_master_inst (.clk_sys_i(clk_sys), .so_i(so), .so_oe_i(so_oe),
    .cs_n_o(cs_n),
    .sck_o(sck), .si_o(si), .hold_n_o(hold_n), .rx_o(rx), .rx_vld_o(rx_vld));
  task automatic cmp(input logic [7:0] got, input logic [7:0] want);
    checks_done++;
    if (got !== want) begin
      error_cnt++;
      $display("Error at %0t: got %h want %h", $time, got, want);
    end
  endtask : cmp
  always @(posedge clk_sys) if (rx_vld === 1'b1) cmp(rx, exp_q.pop_front());
  always @(posedge clk_sys) if (so_oe === 1'b1) oe_seen <= 1'b1;
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (40000) @(posedge clk_sys);
    error_cnt++;
    end_of_test();
  end
  // ----------------------------------------------------------------
  // frames: opcode, address for array ops, n data bytes (reads noted)
  // ----------------------------------------------------------------
  task automatic fr(input logic [7:0] o, input logic [10:0] a, input logic [7:0] b0,
                    input logic [7:0] b1, input int n, input logic m3 = 1'b0,
                    input int hb = -1);
    logic rd;
    rd = (o == OPC_STAT_RD) || (o == OPC_ARR_RD);
    sepc_spi_master_inst.begin_f(m3);
    sepc_spi_master_inst.xfer(o, 1'b0, -1);
    if (o == OPC_ARR_RD || o == OPC_ARR_WR) begin
      sepc_spi_master_inst.xfer({5'h1f, a[10:8]}, 1'b0, -1);
      sepc_spi_master_inst.xfer(a[7:0], 1'b0, -1);
    end
    for (int i = 0; i < n; i++) begin
      if (rd) exp_q.push_back(i == 0 ? b0 : b1);
      sepc_spi_master_inst.xfer(rd ? 8'h00 : (i == 0 ? b0 : b1), rd, i == 0 ? hb : -1);
    end
    sepc_spi_master_inst.end_f();
  endtask : fr
  task automatic sr(input logic [7:0] e);
    fr(OPC_STAT_RD, 11'h0, e, e, 2);
  endtask : sr
  task automatic wl();
    fr(OPC_SET_LATCH, 11'h0, 8'h00, 8'h00, 0);
  endtask : wl
  task automatic settle();
    repeat (WC + 60) @(negedge clk_sys);
  endtask : settle
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'ha867f22e));
    foreach (d[i]) d[i] = $urandom;
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    sr(8'h00);
    cmp({7'h0, so_oe}, 8'h00);
    oe_seen = 1'b0;
    fr(8'h07, 11'h0, 8'h5a, 8'h00, 1);
    cmp({7'h0, oe_seen}, 8'h00);
    fr(8'h0e, 11'h0, 8'h00, 8'h00, 0, 1'b1);
    fr(OPC_STAT_RD, 11'h0, 8'h02, 8'h02, 2, 1'b1);
    fr(OPC_CLR_LATCH, 11'h0, 8'h00, 8'h00, 0);
    sr(8'h00);
    $display("test latch done");
    wl();
    fr(OPC_ARR_WR, 11'h7ff, d[0], d[1], 2);
    sr(8'hff);
    wl();
    settle();
    sr(8'h00);
    wl();
    fr(OPC_ARR_WR, 11'h000, d[2], 8'h00, 1);
    settle();
    fr(OPC_ARR_RD, 11'h7ff, d[0], d[2], 2);
    fr(OPC_ARR_RD, 11'h7e0, d[1], 8'h00, 1);
    fr(OPC_ARR_WR, 11'h000, d[3], 8'h00, 1);
    settle();
    fr(OPC_ARR_RD, 11'h000, d[2], 8'h00, 1);
    $display("test array done");
    wl();
    fr(OPC_STAT_WR, 11'h0, 8'h74, 8'h00, 1);
    settle();
    sr(8'h04);
    wl();
    fr(OPC_ARR_WR, 11'h7e0, d[3], 8'h00, 1);
    settle();
    wl();
    fr(OPC_ARR_WR, 11'h5ff, d[3], 8'h00, 1);
    settle();
    fr(OPC_ARR_RD, 11'h7e0, d[1], 8'h00, 1);
    fr(OPC_ARR_RD, 11'h5ff, d[3], 8'h00, 1);
    $display("test guard done");
    wl();
    fr(OPC_STAT_WR, 11'h0, 8'h84, 8'h00, 1);
    settle();
    sr(8'h84);
    wp_n = 1'b0;
    wl();
    fr(OPC_STAT_WR, 11'h0, 8'h00, 8'h00, 1);
    settle();
    sr(8'h84);
    wl();
    fr(OPC_ARR_WR, 11'h000, d[1], 8'h00, 1);
    settle();
    // start at the top so the wrap lands on the byte just written under protection
    fr(OPC_ARR_RD, 11'h7ff, d[0], d[1], 2, 1'b0, 3);
    wp_n = 1'b1;
    $display("test protect done");
    end_of_test();
  end
endmodule : sepc_core_bench
